/* File: mbl_consts.svh */
// Purpose: shared constants of the matrix bitwise logic unit
// Assumes: included by its bare name wherever the numbers are needed
// Notes: widths, limits and reset values only; no logic here
`ifndef MBL_CONSTS_SVH
`define MBL_CONSTS_SVH

// one matrix word and the bits it holds
`define MBL_WORD_W 16
`define MBL_WORD_LOG2 4
// matrix length limits, in words
`define MBL_LEN_MIN 2
`define MBL_LEN_MAX 256
// bit pointer register width
`define MBL_PTR_W 16
// default widths of length and address ports
`define MBL_LEN_W_DEF 9
`define MBL_ADDR_W_DEF 16
// reset values
`define MBL_RST_BIT 1'b0
`define MBL_RST_WORD 16'h0000

`endif

/* File: mbl_pkg.sv */
// Purpose: types of the matrix bitwise logic unit
// Assumes: nothing beyond the constants header
// Notes: operation, direction and sequencer state enumerations
package mbl_pkg;

  // bitwise operation applied between the two source matrices
  typedef enum logic [1:0] {
    matrix_and_op,
    matrix_or_op,
    matrix_xor_op
  } mbl_op_t;

  // pointer step direction: left moves toward higher bit numbers
  typedef enum logic {
    mbl_dir_right,
    mbl_dir_left
  } mbl_dir_t;

  // word sequencer states
  typedef enum logic [1:0] {
    mbl_idle,
    mbl_read,
    mbl_write
  } mbl_state_t;

endpackage

/* File: mbl_unit.sv */
// Purpose: word-serial AND/OR/XOR between two bit matrices into a third
// Assumes: data memory on clk, read data valid the cycle after rd_en
// Notes: two cycles per word; a write overlaps the next word's read
// Notes: a destination equal to a source is safe, since word i is always
// read before word i is written; a destination one word above a source
// relies on the memory returning old data on a same-cycle read and write
// Notes: the pointer check uses the live length, not the latched one
//
// Contract
// - a matrix is two or more consecutive 16-bit words, 16 bits each
// - bits are numbered 0 to 16L-1, handled as bits, not numbers
// - a 16-bit bit pointer is valid from 0 to 16L-1
// - left means toward higher bit numbers, right toward lower
// - run while enable is high, or on its rising edge in pulse form
// - AND gives 1 only where both source bits are 1
// - OR gives 0 only where both source bits are 0
// - XOR gives 1 where the two source bits differ
// - every destination bit from 0 to the last is written
// - a destination equal to a source still gives correct results
`include "mbl_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module mbl_unit #(
  parameter int LEN_W = `MBL_LEN_W_DEF,
  parameter int ADDR_W = `MBL_ADDR_W_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the instruction sequencer
  input wire logic enable,
  input wire logic pulse_mode,
  input wire mbl_pkg::mbl_op_t op,
  input wire logic [ADDR_W-1:0] first_source_base,
  input wire logic [ADDR_W-1:0] second_source_base,
  input wire logic [ADDR_W-1:0] destination_base,
  input wire logic [LEN_W-1:0] length,
  // status back to the sequencer
  output logic busy_r,
  output logic done_r,
  output logic req_err_r,
  // data memory read ports
  output logic rd_en_r,
  output logic [ADDR_W-1:0] rd_a_addr_r,
  output logic [ADDR_W-1:0] rd_b_addr_r,
  input wire logic [`MBL_WORD_W-1:0] rd_a_data,
  input wire logic [`MBL_WORD_W-1:0] rd_b_data,
  // data memory write port
  output logic wr_en_r,
  output logic [ADDR_W-1:0] wr_addr_r,
  output logic [`MBL_WORD_W-1:0] wr_data_r,
  // bit pointer check and step
  input wire logic [`MBL_PTR_W-1:0] bit_pointer,
  input wire mbl_pkg::mbl_dir_t step_dir,
  output logic [`MBL_PTR_W-1:0] ptr_step_r,
  output logic ptr_err_r
);
  import mbl_pkg::*;

  // refuse widths the pointer arithmetic cannot serve
  if (LEN_W < 9 || LEN_W > 12 || ADDR_W < LEN_W) begin : g_chk
    $error("mbl_unit: need 9 <= LEN_W <= 12 and ADDR_W >= LEN_W");
  end

  // the bit number arithmetic assumes a power-of-two word width
  if (`MBL_WORD_W != (1 << `MBL_WORD_LOG2)) begin : g_chk_word
    $error("mbl_unit: word width and its log2 disagree");
  end

  // a bit number of the longest matrix must fit the pointer register
  if (`MBL_PTR_W < LEN_W + `MBL_WORD_LOG2) begin : g_chk_ptr
    $error("mbl_unit: pointer too narrow for the longest matrix");
  end

  localparam logic [LEN_W-1:0] LEN_MIN = LEN_W'(`MBL_LEN_MIN);
  localparam logic [LEN_W-1:0] LEN_MAX = LEN_W'(`MBL_LEN_MAX);
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);
  localparam logic [`MBL_PTR_W-1:0] PTR_ONE = `MBL_PTR_W'(1);
  localparam logic [`MBL_PTR_W-1:0] PTR_ZERO = `MBL_PTR_W'(0);

  // length is legal only from two words up to the maximum
  function automatic logic len_ok(input logic [LEN_W-1:0] l);
    len_ok = (l >= LEN_MIN) && (l <= LEN_MAX);
  endfunction

  // bitwise combine of one word pair, bit n with bit n only
  function automatic logic [`MBL_WORD_W-1:0] apply_op(
    input mbl_op_t o,
    input logic [`MBL_WORD_W-1:0] a,
    input logic [`MBL_WORD_W-1:0] b
  );
    case (o)
      matrix_and_op: apply_op = a & b;
      matrix_or_op: apply_op = a | b;
      matrix_xor_op: apply_op = a ^ b;
      default: apply_op = `MBL_RST_WORD;
    endcase
  endfunction

  // widen a word index to an address
  function automatic logic [ADDR_W-1:0] ext(input logic [LEN_W-1:0] i);
    ext = ADDR_W'(i);
  endfunction

  // highest bit number of a matrix of l words, 16L-1
  function automatic logic [`MBL_PTR_W-1:0] last_bit(
    input logic [LEN_W-1:0] l
  );
    last_bit = (`MBL_PTR_W'(l) << `MBL_WORD_LOG2) - PTR_ONE;
  endfunction

  mbl_state_t state_r;
  logic enable_prev_r;
  mbl_op_t op_r;
  logic [LEN_W-1:0] len_r;
  logic [LEN_W-1:0] idx_r;
  logic [ADDR_W-1:0] a_base_r;
  logic [ADDR_W-1:0] b_base_r;
  logic [ADDR_W-1:0] d_base_r;
  mbl_state_t state_nxt;
  logic [LEN_W-1:0] idx_nxt;
  logic busy_nxt;
  logic done_nxt;

  // trigger: level form runs while high, pulse form on 0 to 1 only
  // enable_prev_r resets low, so enable high at release counts as an edge
  wire logic enable_rise = enable & ~enable_prev_r;
  wire logic trig = pulse_mode ? enable_rise : enable;
  wire logic op_ok = (op == matrix_and_op) || (op == matrix_or_op) ||
                     (op == matrix_xor_op);
  wire logic req_ok = len_ok(length) && op_ok;
  wire logic idle = (state_r == mbl_idle);
  wire logic start = trig && idle && req_ok;
  wire logic reject = trig && idle && !req_ok;
  wire logic last_word = (idx_r == (len_r - LEN_ONE));
  wire logic [LEN_W-1:0] idx_inc = idx_r + LEN_ONE;
  wire logic [`MBL_WORD_W-1:0] result = apply_op(op_r, rd_a_data, rd_b_data);

  // pointer limit 16L-1 and one step in either direction
  wire logic [`MBL_PTR_W-1:0] ptr_last = last_bit(length);
  wire logic ptr_bad = !len_ok(length) || (bit_pointer > ptr_last);
  wire logic [`MBL_PTR_W-1:0] ptr_left =
    (bit_pointer == ptr_last) ? PTR_ZERO : bit_pointer + PTR_ONE;
  wire logic [`MBL_PTR_W-1:0] ptr_right =
    (bit_pointer == PTR_ZERO) ? ptr_last : bit_pointer - PTR_ONE;
  wire logic [`MBL_PTR_W-1:0] ptr_step =
    (step_dir == mbl_dir_left) ? ptr_left : ptr_right;
  // an out-of-range pointer is handed back untouched rather than stepped
  wire logic [`MBL_PTR_W-1:0] ptr_step_nxt =
    ptr_bad ? bit_pointer : ptr_step;

  // enable history for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_prev_r <= `MBL_RST_BIT;
    end else begin
      enable_prev_r <= enable;
    end
  end

  // request latch, taken only when a run starts
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r <= matrix_and_op;
      len_r <= '0;
      a_base_r <= '0;
      b_base_r <= '0;
      d_base_r <= '0;
    end else if (start) begin
      op_r <= op;
      len_r <= length;
      a_base_r <= first_source_base;
      b_base_r <= second_source_base;
      d_base_r <= destination_base;
    end
  end

  // word sequencer decode: read pair, then write result while next pair
  // reads; triggers seen while busy are ignored, not queued
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    unique case (state_r)
      mbl_idle: begin
        if (start) begin
          idx_nxt = '0;
          busy_nxt = 1'b1;
          state_nxt = mbl_read;
        end
      end
      mbl_read: begin
        state_nxt = mbl_write;
      end
      mbl_write: begin
        if (last_word) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = mbl_idle;
        end else begin
          idx_nxt = idx_inc;
          state_nxt = mbl_read;
        end
      end
      default: begin
        busy_nxt = 1'b0;
        state_nxt = mbl_idle;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= mbl_idle;
      idx_r <= '0;
      busy_r <= `MBL_RST_BIT;
      done_r <= `MBL_RST_BIT;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // read decode: first pair on start, next pair during a write, so the
  // read of word i+1 always runs in the same cycle as the write of word i
  wire logic rd_next = (state_r == mbl_write) && !last_word;
  wire logic rd_en_nxt = start || rd_next;
  wire logic [ADDR_W-1:0] rd_a_addr_nxt =
    start ? first_source_base : a_base_r + ext(idx_inc);
  wire logic [ADDR_W-1:0] rd_b_addr_nxt =
    start ? second_source_base : b_base_r + ext(idx_inc);

  // read strobes: addresses hold between reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_en_r <= `MBL_RST_BIT;
      rd_a_addr_r <= '0;
      rd_b_addr_r <= '0;
    end else begin
      rd_en_r <= rd_en_nxt;
      if (rd_en_nxt) begin
        rd_a_addr_r <= rd_a_addr_nxt;
        rd_b_addr_r <= rd_b_addr_nxt;
      end
    end
  end

  // write decode: one word per write state, destination base plus index
  wire logic wr_en_nxt = (state_r == mbl_write);
  wire logic [ADDR_W-1:0] wr_addr_nxt = d_base_r + ext(idx_r);

  // write strobe: only inside a triggered run, one word at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_en_r <= `MBL_RST_BIT;
      wr_addr_r <= '0;
      wr_data_r <= `MBL_RST_WORD;
    end else begin
      wr_en_r <= wr_en_nxt;
      if (wr_en_nxt) begin
        wr_addr_r <= wr_addr_nxt;
        wr_data_r <= result;
      end
    end
  end

  // refused request flag, one cycle per refused trigger
  always_ff @(posedge clk) begin
    if (rst) begin
      req_err_r <= `MBL_RST_BIT;
    end else begin
      req_err_r <= reject;
    end
  end

  // bit pointer check and step, refreshed every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_step_r <= '0;
      ptr_err_r <= `MBL_RST_BIT;
    end else begin
      ptr_step_r <= ptr_step_nxt;
      ptr_err_r <= ptr_bad;
    end
  end

endmodule

`default_nettype wire

/* File: mbl_unit_properties.sv */
// Purpose: port assertions for the matrix logic unit
// Assumes: op stays put while a run is busy
// Notes: bound into every unit instance
`timescale 1ns/1ns
`default_nettype none
module mbl_unit_properties #(
  parameter int ADDR_W = 16
) (
  // clock, reset, status
  input wire logic clk,
  input wire logic rst,
  input wire mbl_pkg::mbl_op_t op,
  input wire logic busy_r,
  input wire logic done_r,
  // memory side
  input wire logic rd_en_r,
  input wire logic [15:0] rd_a_data,
  input wire logic [15:0] rd_b_data,
  input wire logic wr_en_r,
  input wire logic [ADDR_W-1:0] wr_addr_r,
  input wire logic [15:0] wr_data_r,
  // pointer
  input wire logic [15:0] bit_pointer,
  input wire mbl_pkg::mbl_dir_t step_dir,
  input wire logic [15:0] ptr_step_r,
  input wire logic ptr_err_r
);
  import mbl_pkg::*;
  logic [15:0] qa;
  logic [15:0] qb;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // read data one cycle old, the pair a write must combine
  always_ff @(posedge clk) begin
    qa <= rd_a_data;
    qb <= rd_b_data;
  end
  property p_and; wr_en_r && op == matrix_and_op |->
    wr_data_r == (qa & qb); endproperty
  a_and: assert property (p_and) else $error("and word wrong");
  property p_or; wr_en_r && op == matrix_or_op |->
    wr_data_r == (qa | qb); endproperty
  a_or: assert property (p_or) else $error("or word wrong");
  property p_xor; wr_en_r && op == matrix_xor_op |->
    wr_data_r == (qa ^ qb); endproperty
  a_xor: assert property (p_xor) else $error("xor word wrong");
  property p_wr; wr_en_r |-> $past(rd_en_r, 2); endproperty
  a_wr: assert property (p_wr) else $error("write without read");
  property p_addr; wr_en_r && !done_r |->
    ##2 wr_en_r && wr_addr_r == $past(wr_addr_r, 2) + 1'b1; endproperty
  a_addr: assert property (p_addr) else $error("word skipped");
  property p_done; done_r |-> wr_en_r && !busy_r; endproperty
  a_done: assert property (p_done) else $error("done out of step");
  property p_perr; ptr_err_r |-> ptr_step_r == $past(bit_pointer);
  endproperty
  a_perr: assert property (p_perr) else $error("bad pointer moved");
  property p_left; !$past(rst) && !ptr_err_r && $past(bit_pointer) < 16'd31
    && $past(step_dir) == mbl_dir_left |->
    ptr_step_r == $past(bit_pointer) + 1'b1; endproperty
  a_left: assert property (p_left) else $error("left step wrong");
endmodule
bind mbl_unit mbl_unit_properties #(.ADDR_W(ADDR_W)) i_chk (.clk, .rst,
  .op, .busy_r, .done_r, .rd_en_r, .rd_a_data, .rd_b_data, .wr_en_r,
  .wr_addr_r, .wr_data_r, .bit_pointer, .step_dir, .ptr_step_r, .ptr_err_r);
`default_nettype wire

/* File: mbl_mem_model.sv */
// Purpose: data register memory facing the unit
// Assumes: read data one cycle after a read strobe
// Notes: data lines toggle between reads rather than hold
`timescale 1ns/1ns
`default_nettype none
module mbl_mem_model (
  // clock and read side
  input wire logic clk,
  input wire logic rd_en,
  input wire logic [15:0] ra,
  input wire logic [15:0] rb,
  output logic [15:0] da,
  output logic [15:0] db,
  // write side
  input wire logic wr_en,
  input wire logic [15:0] wa,
  input wire logic [15:0] wd
);
  logic [15:0] mem [64]; // 16-bit words
  // read returns old data when a write hits the same word
  always @(posedge clk) begin
    da <= rd_en ? mem[ra[5:0]] : ~da;
    db <= rd_en ? mem[rb[5:0]] : ~db;
    if (wr_en) mem[wa[5:0]] <= wd;
  end
endmodule
`default_nettype wire

/* File: mbl_unit_tb.sv */
// Purpose: self-checking bench for the matrix logic unit
// Assumes: memory model answers one cycle after a read
// Notes: expected words are worked out here from the bit rules
`timescale 1ns/1ns
`default_nettype none
module mbl_unit_tb;
  import mbl_pkg::*;
  logic clk, rst, enable, pulse_mode, busy_r, done_r, req_err_r, rd_en_r;
  logic wr_en_r, ptr_err_r;
  mbl_op_t op;
  mbl_dir_t step_dir;
  logic [15:0] fa, sa, da, ra, rb, rd_a_data, rd_b_data, wa, wd, bp, ps;
  logic [8:0] length;
  int errors, check_count, cyc;
  mbl_unit i_dut (.clk, .rst, .enable, .pulse_mode, .op,
    .first_source_base(fa), .second_source_base(sa), .destination_base(da),
    .length, .busy_r, .done_r, .req_err_r, .rd_en_r, .rd_a_addr_r(ra),
    .rd_b_addr_r(rb), .rd_a_data, .rd_b_data, .wr_en_r, .wr_addr_r(wa),
    .wr_data_r(wd), .bit_pointer(bp), .step_dir, .ptr_step_r(ps), .ptr_err_r);
  mbl_mem_model i_mem (.clk, .rd_en(rd_en_r), .ra, .rb, .da(rd_a_data),
    .db(rd_b_data), .wr_en(wr_en_r), .wa, .wd);
  // clock and a hang guard
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  // one pulse-started run, then every word and the word past the end
  task run(input mbl_op_t o, input int l, input int a, b, d);
    logic [15:0] e [8];
    int n;
    for (int i = 0; i < l; i++) begin
      i_mem.mem[a+i] = 16'h0ff0 ^ 16'(i * 3);
      i_mem.mem[b+i] = 16'h3c5a + 16'(i);
      e[i] = o == matrix_and_op ? i_mem.mem[a+i] & i_mem.mem[b+i] :
        o == matrix_or_op ? i_mem.mem[a+i] | i_mem.mem[b+i] :
        i_mem.mem[a+i] ^ i_mem.mem[b+i];
    end
    i_mem.mem[d+l] = 16'h5555;
    @(posedge clk);
    {fa, sa, da, length} <= {16'(a), 16'(b), 16'(d), 9'(l)};
    op <= o;
    enable <= 1'b1;
    @(posedge clk);
    enable <= 1'b0;
    n = 0;
    while (done_r !== 1'b1 && n < 99) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cycles", 16'(2 * l), 16'(n));
    @(posedge clk);
    #1 for (int i = 0; i < l; i++) chk("word", e[i], i_mem.mem[d+i]);
    chk("beyond", 16'h5555, i_mem.mem[d+l]);
    $display("test run end");
  endtask
  // bad length or op is refused with no run
  task refuse(input mbl_op_t o, input logic [8:0] l);
    @(posedge clk);
    op <= o;
    {length, enable} <= {l, 1'b1};
    @(posedge clk);
    #1 chk("refused", 16'h1, {15'h0, req_err_r});
    chk("idle", 16'h0, {15'h0, busy_r});
    enable <= 1'b0;
    $display("test refuse end");
  endtask
  // enable held high for twenty cycles, runs counted
  task hold(input logic pm, input int x);
    int c;
    c = 0;
    @(posedge clk);
    op <= matrix_xor_op;
    {pulse_mode, length, enable} <= {pm, 9'd2, 1'b1};
    repeat (20) begin
      @(posedge clk);
      #1 c += int'(done_r);
    end
    {enable, pulse_mode} <= 2'b01;
    repeat (12) @(posedge clk);
    chk("runs", 16'(x), 16'(c));
    $display("test hold end");
  endtask
  // pointer step and range check, one cycle later
  task ptr(input logic [15:0] p, input mbl_dir_t s, input logic [16:0] e);
    @(posedge clk);
    step_dir <= s;
    {bp, length} <= {p, 9'd2};
    @(posedge clk);
    #1 chk("step", e[15:0], ps);
    chk("perr", {15'h0, e[16]}, {15'h0, ptr_err_r});
  endtask
  initial begin
    {rst, enable, pulse_mode} = 3'b101;
    op = matrix_and_op;
    step_dir = mbl_dir_left;
    {length, fa, sa, da, bp, errors, check_count, cyc} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    run(matrix_and_op, 2, 0, 8, 16);
    run(matrix_or_op, 5, 0, 8, 8);
    run(matrix_xor_op, 8, 20, 30, 40);
    refuse(matrix_and_op, 9'd1);
    refuse(mbl_op_t'(2'h3), 9'd2);
    hold(1'b1, 1);
    hold(1'b0, 4);
    ptr(16'd31, mbl_dir_left, 17'h00000);
    ptr(16'd0, mbl_dir_right, 17'h0001f);
    ptr(16'd7, mbl_dir_left, 17'h00008);
    ptr(16'd32, mbl_dir_left, 17'h10020);
    $display("test ptr end");
    report_and_stop();
  end
endmodule
`default_nettype wire
